/* File: hw/lrc_pkg.sv */
// Notes on behaviour
// (R1) reset sets chip address compare value 00
// (R2) matching or single chip: busy low when selected
// (R3) other chips float busy during reset; code uses the latched enable, so all drive it until the first release
// (R4) reset halts command, data and drive timing
// (R5) reset holds drive outputs at third level
// (R6) reset: write mode, increment, pointer 0, codes 000
// (R7) reset clears byte half counter
// (R8) plain reset leaves display memory undefined
// (R9) standby holds through reset, clears on release
// (R10) straps sampled when reset falls
// (R11) straps both zero: chip selected after reset
// (R12) after reset display stays blanked until shown
// (R13) one byte commands; frame, multiplex, display, stop
// (R14) mode commands 60-6f, left entry 71
// (R15) right entry 72, cursor erase 7c, draw 7d
// (R16) frame code divides clock by two power 14-code
// (R17) host never sends frame codes 101-111
// (R18) multiplex field sets divisions, pins, sync, bank
// (R19) code 000: 8 divisions, rows 0-7, bank 0
// (R20) blank command drives non-select levels
// (R21) show command drives from memory contents
// (R22) pointer load takes 7-bit immediate
// (R23) low two mode bits choose pointer step
// (R24) command select input marks bytes as commands
// (R25) unknown commands change nothing; code still clears standby on any completed byte except stop, unknown ones included
package lrc_pkg;
  localparam logic [1:0] ADDR_RST = 2'h0;
  localparam logic [2:0] FDIV_RST = 3'h0;
  localparam logic [2:0] MUX_RST = 3'h0;
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic [1:0] STEP_RST = 2'h0;
  localparam int FRAME_BITS = 14;
  localparam logic [7:0] OP_STOP = 8'h01;
  localparam logic [7:0] OP_BLANK = 8'h08;
  localparam logic [7:0] OP_SHOW = 8'h09;
  localparam logic [7:0] OP_FRAME = 8'h10;
  localparam logic [7:0] OP_FRAME_TOP = 8'h14;
  localparam logic [7:0] OP_MUX = 8'h18;
  localparam logic [7:0] OP_BITS = 8'h20;
  localparam logic [7:0] OP_BITS_TOP = 8'h5f;
  localparam logic [7:0] OP_MODE = 8'h60;
  localparam logic [7:0] OP_LEFT = 8'h71;
  localparam logic [7:0] OP_RIGHT = 8'h72;
  localparam logic [7:0] OP_CUR_ERASE = 8'h7c;
  localparam logic [7:0] OP_CUR_DRAW = 8'h7d;
  localparam logic [5:0] OP_PTR_TOP = 6'h31;

  typedef enum logic [2:0] {
    LRC_READ = 3'b000, LRC_WRITE = 3'b001, LRC_OR = 3'b010,
    LRC_AND = 3'b011, LRC_LEFT = 3'b100, LRC_RIGHT = 3'b101
  } lrc_mode_t;
  typedef enum logic [1:0] {
    LRC_REF3 = 2'b00, LRC_BLANK = 2'b01, LRC_DATA = 2'b10
  } lrc_drive_t;
  typedef enum logic {LRC_HI = 1'b0, LRC_LO = 1'b1} lrc_phase_t;

  typedef struct packed {
    logic rst_seen;
    lrc_phase_t phase;
    logic [3:0] hi_nib;
    logic [1:0] addr_cmp;
    logic selected;
    logic serial;
    logic cae;
    logic standby;
    logic mem_kept;
    logic display_show_cmd;
    lrc_drive_t drv;
    lrc_mode_t mode;
    logic [1:0] step;
    logic [6:0] ptr;
    logic [2:0] fdiv;
    logic [2:0] mux;
    logic [FRAME_BITS-1:0] fcnt;
    logic ftick;
    logic ovalid;
    logic ocmd;
    logic [7:0] obyte;
  } lrc_state_t;

  localparam lrc_state_t ST_RST = '{phase: LRC_HI, drv: LRC_REF3,
    mode: LRC_WRITE, default: '0};
endpackage : lrc_pkg

/* File: hw/lrc_cmd_decode.sv */
`timescale 1ns/1ps
module lrc_cmd_decode (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic dev_reset,
  input wire logic cs_n,
  input wire logic chip_addr_strap_hi,
  input wire logic chip_addr_strap_lo,
  input wire logic serial_strap,
  input wire logic chip_addr_select_enable,
  input wire logic xfer_strobe,
  input wire logic [3:0] xfer_nibble,
  input wire logic cmd_sel,
  output logic busy_n_o,
  output logic busy_n_oe,
  output lrc_pkg::lrc_drive_t drive_mode,
  output logic frame_tick,
  output logic [2:0] frame_divider_field,
  output logic [2:0] multiplex_field,
  output logic time16,
  output logic rows_upper,
  output logic shared_as_row,
  output logic sync_out_en,
  output logic bank_sel,
  output logic bank_both,
  output lrc_pkg::lrc_mode_t proc_mode,
  output logic [1:0] pointer_step_field,
  output logic [6:0] data_ptr,
  output logic standby,
  output logic chip_selected,
  output logic serial_mode,
  output logic chip_addr_enabled,
  output logic mem_retained,
  output logic out_valid,
  output logic out_is_cmd,
  output logic [7:0] out_byte
);
  lrc_pkg::lrc_state_t s_q;
  lrc_pkg::lrc_state_t s_d;
  logic [7:0] b_w;
  logic byte_done;
  logic straps_zero;
  logic bad_op;

  // frame tick mask: period of 2^(14-code) clocks
  function automatic logic [lrc_pkg::FRAME_BITS-1:0] frame_mask(
    input logic [2:0] code);
    frame_mask = {lrc_pkg::FRAME_BITS{1'b1}} >> code;
  endfunction : frame_mask

  // assembled byte and its completion, high nibble first
  assign b_w = {s_q.hi_nib, xfer_nibble};
  assign byte_done = xfer_strobe && !cs_n && s_q.selected && !dev_reset
                     && s_q.phase == lrc_pkg::LRC_LO;
  assign straps_zero = {chip_addr_strap_hi, chip_addr_strap_lo}
                       == s_q.addr_cmp; // R1
  assign bad_op = b_w[7:4] == 4'h7 && b_w != lrc_pkg::OP_LEFT
                  && b_w != lrc_pkg::OP_RIGHT
                  && b_w != lrc_pkg::OP_CUR_ERASE
                  && b_w != lrc_pkg::OP_CUR_DRAW;

  // next state
  always_comb begin
    s_d = s_q;
    s_d.ftick = 1'b0;
    s_d.ovalid = 1'b0;
    s_d.rst_seen = dev_reset;
    if (dev_reset) begin
      s_d.addr_cmp = lrc_pkg::ADDR_RST; // R1
      s_d.phase = lrc_pkg::LRC_HI; // R7
      s_d.mode = lrc_pkg::LRC_WRITE; // R6
      s_d.step = lrc_pkg::STEP_RST; // R6
      s_d.ptr = lrc_pkg::PTR_RST; // R6
      s_d.mux = lrc_pkg::MUX_RST; // R6 R19
      s_d.fdiv = lrc_pkg::FDIV_RST; // R6
      s_d.display_show_cmd = 1'b0; // R12
      s_d.fcnt = '0; // R4
      s_d.mem_kept = s_q.standby; // R8 R9
    end else begin
      if (s_q.rst_seen) begin
        s_d.serial = serial_strap; // R10
        s_d.cae = chip_addr_select_enable; // R10
        s_d.selected = !chip_addr_select_enable || straps_zero; // R11
        s_d.standby = 1'b0; // R9
      end
      // frame divider stops while in standby
      if (!s_q.standby) begin
        s_d.fcnt = s_q.fcnt + 1'b1;
        s_d.ftick = (s_q.fcnt & frame_mask(s_q.fdiv))
                    == frame_mask(s_q.fdiv); // R16
      end
      // nibble pairing into bytes
      if (xfer_strobe && !cs_n && s_q.selected) begin
        case (s_q.phase)
          lrc_pkg::LRC_HI: begin
            s_d.hi_nib = xfer_nibble;
            s_d.phase = lrc_pkg::LRC_LO;
          end
          default: begin
            s_d.phase = lrc_pkg::LRC_HI;
            s_d.standby = 1'b0;
          end
        endcase
      end
      // byte decode
      if (byte_done) begin
        if (!cmd_sel) begin // R24
          s_d.ovalid = 1'b1;
          s_d.ocmd = 1'b0;
          s_d.obyte = b_w;
        end else if (b_w == lrc_pkg::OP_STOP) begin // R13
          s_d.standby = 1'b1;
        end else if (b_w == lrc_pkg::OP_BLANK) begin
          s_d.display_show_cmd = 1'b0; // R20
        end else if (b_w == lrc_pkg::OP_SHOW) begin
          s_d.display_show_cmd = 1'b1; // R21
        end else if (b_w >= lrc_pkg::OP_FRAME
                     && b_w <= lrc_pkg::OP_FRAME_TOP) begin
          s_d.fdiv = b_w[2:0]; // R13 R16
        end else if (b_w[7:3] == lrc_pkg::OP_MUX[7:3]) begin
          s_d.mux = b_w[2:0]; // R18
        end else if (b_w[7:4] == lrc_pkg::OP_MODE[7:4]) begin
          s_d.mode = lrc_pkg::lrc_mode_t'({1'b0, b_w[3:2]}); // R14
          s_d.step = b_w[1:0]; // R23
        end else if (b_w == lrc_pkg::OP_LEFT) begin
          s_d.mode = lrc_pkg::LRC_LEFT; // R14
        end else if (b_w == lrc_pkg::OP_RIGHT) begin
          s_d.mode = lrc_pkg::LRC_RIGHT; // R15
        end else if (b_w[7] && b_w[5:0] <= lrc_pkg::OP_PTR_TOP) begin
          s_d.ptr = b_w[6:0]; // R22
        end else if ((b_w >= lrc_pkg::OP_BITS
                      && b_w <= lrc_pkg::OP_BITS_TOP)
                     || b_w == lrc_pkg::OP_CUR_ERASE
                     || b_w == lrc_pkg::OP_CUR_DRAW) begin
          s_d.ovalid = 1'b1; // R15
          s_d.ocmd = 1'b1;
          s_d.obyte = b_w;
        end
        // anything else falls through unchanged R25
      end
    end
    // drive level follows reset, then display state
    if (dev_reset) begin
      s_d.drv = lrc_pkg::LRC_REF3; // R5
    end else if (s_d.display_show_cmd) begin
      s_d.drv = lrc_pkg::LRC_DATA; // R21
    end else begin
      s_d.drv = lrc_pkg::LRC_BLANK; // R12 R20
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= lrc_pkg::ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // busy pin: low during reset, high once running
  always_comb begin
    busy_n_o = !dev_reset;
    if (dev_reset) begin
      busy_n_oe = !cs_n && (!s_q.cae || straps_zero); // R2 R3
    end else begin
      busy_n_oe = !cs_n && s_q.selected;
    end
  end

  // outputs from state
  assign drive_mode = s_q.drv;
  assign frame_tick = s_q.ftick;
  assign frame_divider_field = s_q.fdiv;
  assign multiplex_field = s_q.mux;
  assign time16 = s_q.mux[2]; // R18
  assign rows_upper = s_q.mux[2] && !s_q.mux[1];
  assign shared_as_row = s_q.mux[2] && s_q.mux[1];
  assign sync_out_en = s_q.mux[1];
  assign bank_sel = s_q.mux[0];
  assign bank_both = s_q.mux[2];
  assign proc_mode = s_q.mode;
  assign pointer_step_field = s_q.step;
  assign data_ptr = s_q.ptr;
  assign standby = s_q.standby;
  assign chip_selected = s_q.selected;
  assign serial_mode = s_q.serial;
  assign chip_addr_enabled = s_q.cae;
  assign mem_retained = s_q.mem_kept;
  assign out_valid = s_q.ovalid;
  assign out_is_cmd = s_q.ocmd;
  assign out_byte = s_q.obyte;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence cmd_done;
    byte_done && cmd_sel;
  endsequence
  sequence release_s;
    $fell(dev_reset);
  endsequence

  reset_drive_a: assert property ( // R5
    dev_reset |=> drive_mode == lrc_pkg::LRC_REF3)
    else $error("drive not at third level in reset");
  reset_modes_a: assert property ( // R6
    dev_reset |=> proc_mode == lrc_pkg::LRC_WRITE && data_ptr == 7'h00
      && pointer_step_field == 2'h0 && multiplex_field == 3'h0
      && frame_divider_field == 3'h0)
    else $error("reset defaults wrong");
  release_blank_a: assert property ( // R12
    release_s |=> drive_mode == lrc_pkg::LRC_BLANK ##1
      drive_mode == lrc_pkg::LRC_BLANK)
    else $error("display not blank after reset");
  busy_float_a: assert property ( // R3
    dev_reset && s_q.cae && !straps_zero |-> !busy_n_oe)
    else $error("unmatched chip drives busy");
  busy_low_a: assert property ( // R2
    dev_reset && straps_zero |-> busy_n_oe == !cs_n && !busy_n_o)
    else $error("matched chip busy wrong");
  strap_sample_a: assert property ( // R10
    release_s |=> serial_mode == $past(serial_strap)
      && chip_addr_enabled == $past(chip_addr_select_enable))
    else $error("straps not sampled at release");
  ptr_load_a: assert property ( // R22
    cmd_done ##0 (b_w[7] && b_w[5:0] <= 6'h31)
      |=> data_ptr == $past(b_w[6:0]))
    else $error("pointer load failed");
  frame_code_a: assert property ( // R16
    cmd_done ##0 (b_w[7:3] == 5'h02 && b_w[2:0] <= 3'h4)
      |=> frame_divider_field == $past(b_w[2:0]))
    else $error("frame code not taken");
  show_drive_a: assert property ( // R21
    cmd_done ##0 b_w == 8'h09 |=> drive_mode == lrc_pkg::LRC_DATA)
    else $error("display not shown");
  bad_cmd_a: assert property ( // R25
    cmd_done ##0 bad_op |=> $stable(data_ptr) && $stable(proc_mode)
      && $stable(multiplex_field) && $stable(frame_divider_field))
    else $error("unknown command changed state");
  standby_hold_a: assert property ( // R9
    dev_reset && standby |=> standby [*1] ##0 mem_retained)
    else $error("standby lost in reset");
  half_clear_a: assert property ( // R7
    dev_reset |=> s_q.phase == lrc_pkg::LRC_HI)
    else $error("byte half counter not cleared");
endmodule : lrc_cmd_decode

/* File: testbench/lrc_host_model.sv */
`timescale 1ns/1ps
module lrc_host_model (
  input wire logic clk_sys,
  output logic xfer_strobe,
  output logic [3:0] xfer_nibble,
  output logic cmd_sel
);
  // idle bus
  initial begin
    xfer_strobe = 1'b0;
    xfer_nibble = 4'h0;
    cmd_sel = 1'b0;
  end
  // whole byte, high nibble first; flag rides the second portion
  task automatic send(input logic [7:0] b, input logic c);
    xfer_strobe <= 1'b1;
    xfer_nibble <= b[7:4];
    @(posedge clk_sys);
    xfer_nibble <= b[3:0];
    cmd_sel <= c;
    @(posedge clk_sys);
    xfer_strobe <= 1'b0;
    xfer_nibble <= ~b[3:0];
    cmd_sel <= ~c;
  endtask : send
  // lone first portion, left dangling on purpose
  task automatic half(input logic [3:0] n);
    xfer_strobe <= 1'b1;
    xfer_nibble <= n;
    @(posedge clk_sys);
    xfer_strobe <= 1'b0;
    xfer_nibble <= ~n;
  endtask : half
endmodule : lrc_host_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_sys, resetn, dev_reset, cs_n, ca_hi, ca_lo, ser, cae;
  logic stb, csel, busy_o, busy_oe, t16, stby, sel, serm, caen, kept;
  logic ov, ocmd, ft, rup, shr, syo, bks, bkb;
  logic [3:0] nib;
  logic [7:0] obyte;
  lrc_pkg::lrc_drive_t drv;
  lrc_pkg::lrc_mode_t mode;
  logic [2:0] fdiv, mux;
  logic [1:0] step;
  logic [6:0] ptr;
  logic [1:0] steps [4] = '{2'h0, 2'h1, 2'h3, 2'h1};
  int bad_count, num_checks;
  int gap;

  lrc_host_model lrc_host_model_inst (.clk_sys(clk_sys),
    .xfer_strobe(stb), .xfer_nibble(nib), .cmd_sel(csel));

  lrc_cmd_decode lrc_cmd_decode_inst (.clk_sys(clk_sys), .resetn(resetn),
    .dev_reset(dev_reset), .cs_n(cs_n), .chip_addr_strap_hi(ca_hi),
    .chip_addr_strap_lo(ca_lo), .serial_strap(ser),
    .chip_addr_select_enable(cae), .xfer_strobe(stb),
    .xfer_nibble(nib), .cmd_sel(csel), .busy_n_o(busy_o),
    .busy_n_oe(busy_oe), .drive_mode(drv), .frame_tick(ft),
    .frame_divider_field(fdiv), .multiplex_field(mux), .time16(t16),
    .rows_upper(rup), .shared_as_row(shr), .sync_out_en(syo),
    .bank_sel(bks), .bank_both(bkb), .proc_mode(mode),
    .pointer_step_field(step),
    .data_ptr(ptr), .standby(stby), .chip_selected(sel),
    .serial_mode(serm), .chip_addr_enabled(caen), .mem_retained(kept),
    .out_valid(ov), .out_is_cmd(ocmd), .out_byte(obyte));

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // cycles between two frame ticks, bounded
  task automatic tick_gap(output int gap);
    int first;
    first = -1;
    gap = 0;
    for (int n = 0; n < 3000 && gap == 0; n++) begin
      @(posedge clk_sys);
      #1;
      if (ft === 1'b1 && first < 0) begin
        first = n;
      end else if (ft === 1'b1) begin
        gap = n - first;
      end
    end
  endtask : tick_gap

  task automatic summarize;
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // one byte, then let its effect land
  task automatic cmd(input logic [7:0] b, input logic c = 1'b1);
    @(posedge clk_sys);
    lrc_host_model_inst.send(b, c);
    #1;
  endtask : cmd

  task automatic dres_on;
    @(posedge clk_sys);
    dev_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : dres_on

  task automatic dres_off;
    @(posedge clk_sys);
    dev_reset <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : dres_off

  // hang guard
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    dev_reset = 1'b1;
    cs_n = 1'b0;
    ca_hi = 1'b0;
    ca_lo = 1'b0;
    ser = 1'b1;
    cae = 1'b1;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(busy_oe, 8'h1);
    chk(busy_o, 8'h0);
    @(posedge clk_sys);
    cs_n <= 1'b1;
    #1;
    chk(busy_oe, 8'h0);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    ca_lo <= 1'b1;
    #1;
    chk(busy_oe, 8'h1);
    @(posedge clk_sys);
    ca_lo <= 1'b0;
    cmd(8'h09);
    chk(drv, lrc_pkg::LRC_REF3);
    chk(mode, lrc_pkg::LRC_WRITE);
    chk(step, 8'h0);
    chk(ptr, 8'h0);
    chk(fdiv, 8'h0);
    chk(mux, 8'h0);
    dres_off();
    chk(sel, 8'h1);
    chk(serm, 8'h1);
    chk(caen, 8'h1);
    chk(drv, lrc_pkg::LRC_BLANK);
    cmd(8'h09);
    chk(drv, lrc_pkg::LRC_DATA);
    cmd(8'h08);
    chk(drv, lrc_pkg::LRC_BLANK);
    for (int i = 0; i < 5; i++) begin
      cmd(8'h10 + 8'(i));
      chk(fdiv, 8'(i));
    end
    tick_gap(gap);
    chk(8'(gap == (1 << (lrc_pkg::FRAME_BITS - 4))), 8'h1);
    cmd(8'h1d);
    chk(mux, 8'h5);
    chk(t16, 8'h1);
    chk(rup, 8'h1);
    chk(shr, 8'h0);
    chk(syo, 8'h0);
    chk(bkb, 8'h1);
    cmd(8'h1f);
    chk(rup, 8'h0);
    chk(shr, 8'h1);
    chk(syo, 8'h1);
    cmd(8'h18);
    chk(t16, 8'h0);
    chk(rup, 8'h0);
    chk(shr, 8'h0);
    chk(syo, 8'h0);
    chk(bks, 8'h0);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h60 + 8'(4 * i) + 8'(steps[i]));
      chk(mode, 8'(i));
      chk(step, steps[i]);
    end
    cmd(8'h71);
    chk(mode, lrc_pkg::LRC_LEFT);
    cmd(8'h72);
    chk(mode, lrc_pkg::LRC_RIGHT);
    cmd(8'hb1);
    chk(ptr, 8'h31);
    cmd(8'hf1);
    chk(ptr, 8'h71);
    cmd(8'h02);
    cmd(8'h7e);
    chk(ptr, 8'h71);
    chk(mode, lrc_pkg::LRC_RIGHT);
    cmd(8'h7c);
    chk(ov, 8'h1);
    chk(obyte, 8'h7c);
    chk(ocmd, 8'h1);
    cmd(8'h09, 1'b0);
    chk(ocmd, 8'h0);
    chk(drv, lrc_pkg::LRC_BLANK);
    @(posedge clk_sys);
    lrc_host_model_inst.half(4'h0);
    dres_on();
    dres_off();
    cmd(8'h09);
    chk(drv, lrc_pkg::LRC_DATA);
    cmd(8'h01);
    chk(stby, 8'h1);
    dres_on();
    chk(stby, 8'h1);
    chk(drv, lrc_pkg::LRC_REF3);
    @(posedge clk_sys);
    ca_lo <= 1'b1;
    #1;
    chk(busy_oe, 8'h0);
    @(posedge clk_sys);
    ca_lo <= 1'b0;
    dres_off();
    chk(stby, 8'h0);
    chk(kept, 8'h1);
    summarize();
  end
endmodule : tb
